// ### acr_regs.sv
// Register bank for channel 0/1 calibration and channel 1 configuration
//
// Behaviour
// - Offset trim is 24 bits: high 16 in one register, low 8 in bits 15:8 of the next, reset 0.
// - Gain trim is 24 bits: high 16 in one register, low 8 in the upper byte of the next.
// - Gain high resets to 8000h and gain low to 0, so only the top gain bit is set.
// - Config bits 15:6 hold a signed phase delay in modulator cycles, reset 0.
// - Config bit 2 bypasses the channel high-pass when set, else global coefficient rules.
// - Config bits 1:0 pick the input: pins, shorted, positive test, negative test.
// - A global 4-bit coefficient picks 1/4 to 1/32768 by powers of two, 0 disables.
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/10ps
module acr_regs
	import acr_pkg::*;
(
	// ----------------------------------------
	// Clock and reset
	// ----------------------------------------
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// ----------------------------------------
	// AHB-Lite slave
	// ----------------------------------------
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	// ----------------------------------------
	// Datapath controls
	// ----------------------------------------
	output acr_trim_type chan0_trim_o,
	output acr_trim_type chan1_trim_o,
	output acr_cfg_type chan1_cfg_o
);

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic [15:0] chan0_offset_high_field_r;
	logic [7:0] chan0_offset_low_field_r;
	logic [15:0] chan0_gain_high_field_r;
	logic [7:0] chan0_gain_low_field_r;
	logic [15:0] chan1_offset_high_field_r;
	logic [7:0] chan1_offset_low_field_r;
	logic [15:0] chan1_gain_high_field_r;
	logic [7:0] chan1_gain_low_field_r;
	logic [9:0] chan1_phase_delay_r;
	logic chan1_highpass_bypass_r;
	logic [1:0] chan1_input_select_r;
	logic [3:0] global_highpass_coeff_r;

	// ----------------------------------------
	// Address phase capture
	// ----------------------------------------
	logic wr_pend_r;
	logic [4:0] wr_idx_r;
	logic addr_ok;
	logic take;
	logic [4:0] a_idx;
	logic [31:0] rd_nxt;

	assign take = hsel_i && hready_i && htrans_i[1];
	assign a_idx = haddr_i[ACR_IDX_LSB +: 5];
	// Upper address bits must be clear, or the index would alias
	assign addr_ok = (haddr_i[31:ACR_IDX_LSB + 5] == '0) && (haddr_i[1:0] == 2'h0);

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_pend_r <= 1'b0;
			wr_idx_r <= 5'h00;
		end else if (hready_i) begin
			wr_pend_r <= take && hwrite_i && addr_ok;
			wr_idx_r <= a_idx;
		end
	end

	// ----------------------------------------
	// Write data phase
	// ----------------------------------------
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			chan0_offset_high_field_r <= ACR_ZERO_RST;
			chan0_offset_low_field_r <= ACR_ZERO_RST[15:8];
			chan1_offset_high_field_r <= ACR_ZERO_RST;
			chan1_offset_low_field_r <= ACR_ZERO_RST[15:8];
		end else if (wr_pend_r) begin
			unique case (wr_idx_r)
				ACR_IDX_CH0_OFS_HI: chan0_offset_high_field_r <= hwdata_i[15:0];
				ACR_IDX_CH0_OFS_LO: chan0_offset_low_field_r <= hwdata_i[15:8];
				ACR_IDX_CH1_OFS_HI: chan1_offset_high_field_r <= hwdata_i[15:0];
				ACR_IDX_CH1_OFS_LO: chan1_offset_low_field_r <= hwdata_i[15:8];
				default: ;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			chan0_gain_high_field_r <= ACR_GAIN_HI_RST;
			chan0_gain_low_field_r <= ACR_ZERO_RST[15:8];
			chan1_gain_high_field_r <= ACR_GAIN_HI_RST;
			chan1_gain_low_field_r <= ACR_ZERO_RST[15:8];
		end else if (wr_pend_r) begin
			unique case (wr_idx_r)
				ACR_IDX_CH0_GAIN_HI: chan0_gain_high_field_r <= hwdata_i[15:0];
				ACR_IDX_CH0_GAIN_LO: chan0_gain_low_field_r <= hwdata_i[15:8];
				ACR_IDX_CH1_GAIN_HI: chan1_gain_high_field_r <= hwdata_i[15:0];
				ACR_IDX_CH1_GAIN_LO: chan1_gain_low_field_r <= hwdata_i[15:8];
				default: ;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			chan1_phase_delay_r <= ACR_ZERO_RST[15:6];
			chan1_highpass_bypass_r <= 1'b0;
			chan1_input_select_r <= ACR_SEL_PINS;
			global_highpass_coeff_r <= ACR_COEFF_OFF;
		end else if (wr_pend_r) begin
			if (wr_idx_r == ACR_IDX_CHAN1_CONFIG) begin
				chan1_phase_delay_r <= hwdata_i[ACR_PHASE_LSB +: 10];
				chan1_highpass_bypass_r <= hwdata_i[ACR_BYPASS_BIT];
				chan1_input_select_r <= hwdata_i[ACR_SEL_LSB +: 2];
			end
			if (wr_idx_r == ACR_IDX_GLOBAL) begin
				global_highpass_coeff_r <= hwdata_i[ACR_COEFF_LSB +: 4];
			end
		end
	end

	// ----------------------------------------
	// Read data, registered at the address phase
	// ----------------------------------------
	always_comb begin
		rd_nxt = 32'h0000_0000;
		unique case (a_idx)
			ACR_IDX_CH0_OFS_HI: rd_nxt[15:0] = chan0_offset_high_field_r;
			ACR_IDX_CH0_OFS_LO: rd_nxt[15:8] = chan0_offset_low_field_r;
			ACR_IDX_CH0_GAIN_HI: rd_nxt[15:0] = chan0_gain_high_field_r;
			ACR_IDX_CH0_GAIN_LO: rd_nxt[15:8] = chan0_gain_low_field_r;
			ACR_IDX_CHAN1_CONFIG: begin
				rd_nxt[15:6] = chan1_phase_delay_r;
				rd_nxt[ACR_BYPASS_BIT] = chan1_highpass_bypass_r;
				rd_nxt[1:0] = chan1_input_select_r;
			end
			ACR_IDX_CH1_OFS_HI: rd_nxt[15:0] = chan1_offset_high_field_r;
			ACR_IDX_CH1_OFS_LO: rd_nxt[15:8] = chan1_offset_low_field_r;
			ACR_IDX_CH1_GAIN_HI: rd_nxt[15:0] = chan1_gain_high_field_r;
			ACR_IDX_CH1_GAIN_LO: rd_nxt[15:8] = chan1_gain_low_field_r;
			ACR_IDX_GLOBAL: rd_nxt[3:0] = global_highpass_coeff_r;
			default: rd_nxt = 32'h0000_0000;
		endcase
		if (!addr_ok) begin
			rd_nxt = 32'h0000_0000;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hrdata_o <= 32'h0000_0000;
		end else if (take && !hwrite_i) begin
			hrdata_o <= rd_nxt;
		end
	end

	// Zero wait states; unmapped words read zero and ignore writes
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;

	// ----------------------------------------
	// Datapath outputs
	// ----------------------------------------
	assign chan0_trim_o.offset = {chan0_offset_high_field_r, chan0_offset_low_field_r};
	assign chan0_trim_o.gain = {chan0_gain_high_field_r, chan0_gain_low_field_r};
	assign chan1_trim_o.offset = {chan1_offset_high_field_r, chan1_offset_low_field_r};
	assign chan1_trim_o.gain = {chan1_gain_high_field_r, chan1_gain_low_field_r};
	assign chan1_cfg_o.phase = chan1_phase_delay_r;
	assign chan1_cfg_o.bypass = chan1_highpass_bypass_r;
	assign chan1_cfg_o.sel = acr_sel_type'(chan1_input_select_r);
	// Bypass overrides the global setting; code above 1/32768 is treated as off
	assign chan1_cfg_o.highpass_on = !chan1_highpass_bypass_r
		&& (global_highpass_coeff_r != ACR_COEFF_OFF)
		&& (global_highpass_coeff_r <= ACR_COEFF_MAX);
	// Coefficient is 2^-(code+1)
	assign chan1_cfg_o.shift = global_highpass_coeff_r + 4'h1;

endmodule

// ### acr_pkg.sv
// Package for the channel calibration register bank
package acr_pkg;

	// ----------------------------------------
	// Register indices (byte address = 4 * index)
	// ----------------------------------------
	localparam logic [4:0] ACR_IDX_CH0_OFS_HI = 5'h0A;
	localparam logic [4:0] ACR_IDX_CH0_OFS_LO = 5'h0B;
	localparam logic [4:0] ACR_IDX_CH0_GAIN_HI = 5'h0C;
	localparam logic [4:0] ACR_IDX_CH0_GAIN_LO = 5'h0D;
	localparam logic [4:0] ACR_IDX_CHAN1_CONFIG = 5'h0E;
	localparam logic [4:0] ACR_IDX_CH1_OFS_HI = 5'h0F;
	localparam logic [4:0] ACR_IDX_CH1_OFS_LO = 5'h10;
	localparam logic [4:0] ACR_IDX_CH1_GAIN_HI = 5'h11;
	localparam logic [4:0] ACR_IDX_CH1_GAIN_LO = 5'h12;
	localparam logic [4:0] ACR_IDX_GLOBAL = 5'h08;
	localparam int ACR_IDX_LSB = 2;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int ACR_LOW_BYTE_LSB = 8;
	localparam int ACR_PHASE_LSB = 6;
	localparam int ACR_BYPASS_BIT = 2;
	localparam int ACR_SEL_LSB = 0;
	localparam int ACR_COEFF_LSB = 0;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [15:0] ACR_GAIN_HI_RST = 16'h8000;
	localparam logic [15:0] ACR_ZERO_RST = 16'h0000;

	// ----------------------------------------
	// Encodings
	// ----------------------------------------
	typedef enum logic [1:0] {
		ACR_SEL_PINS = 2'h0,
		ACR_SEL_SHORT = 2'h1,
		ACR_SEL_TEST_POS = 2'h2,
		ACR_SEL_TEST_NEG = 2'h3
	} acr_sel_type;
	localparam logic [3:0] ACR_COEFF_OFF = 4'h0;
	localparam logic [3:0] ACR_COEFF_MAX = 4'hE;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic [23:0] offset;
		logic [23:0] gain;
	} acr_trim_type;

	typedef struct packed {
		logic [9:0] phase;
		logic bypass;
		acr_sel_type sel;
		logic highpass_on;
		logic [3:0] shift;
	} acr_cfg_type;

endpackage

// ### acr_regs_chk.sv
// Assertion checker for the calibration register bank
`timescale 1ns/10ps
module acr_regs_chk
	import acr_pkg::*;
(
	// Bus side
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	input wire logic [31:0] hrdata_o,
	// Datapath side
	input wire acr_trim_type chan0_trim_o,
	input wire acr_trim_type chan1_trim_o,
	input wire acr_cfg_type chan1_cfg_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	logic wr_q;
	logic rd_q;
	logic [31:0] a_q;
	// Data phase tracker, needed because write data lags its address
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			a_q <= 32'h0;
		end else begin
			wr_q <= hsel_i && hready_i && htrans_i[1] && hwrite_i;
			rd_q <= hsel_i && hready_i && htrans_i[1] && !hwrite_i;
			a_q <= haddr_i;
		end
	end
	sequence s_wr(logic [31:0] a); wr_q && a_q == a; endsequence
	property p_ofs; s_wr(32'h40) |=> chan1_trim_o.offset[7:0] == $past(hwdata_i[15:8]); endproperty
	a_ofs: assert property (p_ofs) else $error("offset low byte wrong");
	property p_gain; s_wr(32'h44) |=> chan1_trim_o.gain[23:8] == $past(hwdata_i[15:0]); endproperty
	a_gain: assert property (p_gain) else $error("gain high half wrong");
	property p_grst; $rose(rst_n_i) |-> chan0_trim_o.gain == 24'h800000; endproperty
	a_grst: assert property (p_grst) else $error("gain reset value wrong");
	property p_phase; s_wr(32'h38) |=> chan1_cfg_o.phase == $past(hwdata_i[15:6]); endproperty
	a_phase: assert property (p_phase) else $error("phase field wrong");
	property p_byp; chan1_cfg_o.bypass |-> !chan1_cfg_o.highpass_on; endproperty
	a_byp: assert property (p_byp) else $error("bypass ignored");
	property p_sel; s_wr(32'h38) |=> chan1_cfg_o.sel == $past(hwdata_i[1:0]); endproperty
	a_sel: assert property (p_sel) else $error("input select wrong");
	property p_coef;
		s_wr(32'h20) ##0 hwdata_i[3:0] inside {[4'h1:4'hE]} |=>
			chan1_cfg_o.shift == $past(hwdata_i[3:0]) + 4'h1;
	endproperty
	a_coef: assert property (p_coef) else $error("coefficient shift wrong");
	property p_rhi; rd_q |-> hrdata_o[31:16] == 16'h0; endproperty
	a_rhi: assert property (p_rhi) else $error("upper read bits not zero");
	property p_rlo; rd_q && a_q inside {32'h2C, 32'h34, 32'h40, 32'h48} |-> hrdata_o[7:0] == 8'h0;
	endproperty
	a_rlo: assert property (p_rlo) else $error("reserved low byte not zero");
endmodule
bind acr_regs acr_regs_chk u_chk (.sys_clk_i, .rst_n_i, .hsel_i, .haddr_i, .htrans_i,
	.hwrite_i, .hwdata_i, .hready_i, .hrdata_o, .chan0_trim_o, .chan1_trim_o, .chan1_cfg_o);

// ### acr_regs_tb_top.sv
// Self-checking bench for the calibration register bank
`timescale 1ns/10ps
module acr_regs_tb_top;
	import acr_pkg::*;
	logic sys_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic hsel_i = 1'b0;
	logic hwrite_i = 1'b0;
	logic [1:0] htrans_i = 2'h0;
	logic [31:0] haddr_i = 32'h0;
	logic [31:0] hwdata_i = 32'h0;
	logic [31:0] hrdata_o;
	logic [31:0] rd;
	logic hreadyout_o;
	logic hresp_o;
	acr_trim_type chan0_trim_o;
	acr_trim_type chan1_trim_o;
	acr_cfg_type chan1_cfg_o;
	int err_total = 0;
	int num_checks = 0;
	logic [31:0] adr [10] = '{32'h20, 32'h28, 32'h2C, 32'h30, 32'h34, 32'h38, 32'h3C, 32'h40,
		32'h44, 32'h48};
	logic [31:0] msk [10] = '{32'hF, 32'hFFFF, 32'hFF00, 32'hFFFF, 32'hFF00, 32'hFFC7, 32'hFFFF,
		32'hFF00, 32'hFFFF, 32'hFF00};
	always #2 sys_clk_i = ~sys_clk_i;
	acr_regs DUT (.sys_clk_i, .rst_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i(3'h2),
		.hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o, .chan0_trim_o,
		.chan1_trim_o, .chan1_cfg_o);
	task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, got);
		end
	endtask
	task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
		@(posedge sys_clk_i);
		hsel_i <= 1'b1;
		htrans_i <= 2'h2;
		haddr_i <= a;
		hwrite_i <= w;
		do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
		htrans_i <= 2'h0;
		hwdata_i <= d;
		do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
		rd = hrdata_o;
		// Let the landing write settle before outputs are looked at
		#1;
	endtask
	task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
		bus(a, 1'b0, 32'h0);
		chk($sformatf("read %h", a), exp, rd);
		chk("hresp", 1'b0, hresp_o);
		chk("hreadyout", 1'b1, hreadyout_o);
	endtask
	task automatic summarize;
		$display("checks %0d, mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		#200000;
		err_total++;
		summarize;
	end
	initial begin
		repeat (12) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		for (int i = 0; i < 10; i++) begin
			rchk(adr[i], (adr[i] == 32'h30 || adr[i] == 32'h44) ? 32'h8000 : 32'h0);
		end
		chk("ch0 trim", {24'h0, 24'h800000}, chan0_trim_o);
		chk("chan1_config", 18'h00001, chan1_cfg_o);
		for (int i = 0; i < 10; i++) begin
			bus(adr[i], 1'b1, 32'hFFFF_FFFF);
			rchk(adr[i], msk[i]);
		end
		bus(32'h3C, 1'b1, 32'h1234);
		bus(32'h40, 1'b1, 32'h56AB);
		bus(32'h44, 1'b1, 32'hA5C3);
		bus(32'h48, 1'b1, 32'h7E00);
		chk("ch1 trim", {24'h123456, 24'hA5C37E}, chan1_trim_o);
		bus(32'h20, 1'b1, 32'hFFFF_FFF4);
		for (int b = 0; b < 2; b++) begin
			for (int s = 0; s < 4; s++) begin
				bus(32'h38, 1'b1, {16'hFFFF, 10'h201, 3'h7, b[0], s[1:0]});
				chk("chan1_config", {10'h201, b[0], s[1:0], !b[0], 4'h5}, chan1_cfg_o);
			end
		end
		bus(32'h38, 1'b1, 32'h0);
		for (int c = 0; c < 16; c++) begin
			bus(32'h20, 1'b1, c);
			chk("coeff", {c[3:0] != 4'h0 && c[3:0] != 4'hF, c[3:0] + 4'h1},
				{chan1_cfg_o.highpass_on, chan1_cfg_o.shift});
		end
		bus(32'h4C, 1'b1, 32'hFFFF);
		bus(32'h29, 1'b1, 32'h0);
		rchk(32'h4C, 32'h0);
		rchk(32'h29, 32'h0);
		rchk(32'h28, 32'hFFFF);
		@(posedge sys_clk_i);
		rst_n_i <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		#1;
		chk("ch1 trim", {24'h0, 24'h800000}, chan1_trim_o);
		chk("chan1_config", 18'h00001, chan1_cfg_o);
		summarize;
	end
endmodule
